// ===== design/ocrd_top.sv
// option byte decoder: clock source, wakeup clock, crystal settle, pin remap
// assumes an Avalon-MM master on REF_CLK and OSC_IN from the oscillator pin
//
// Overview of operation
// R1: ext-clock bit 0 drives crystal on both pins; 1 takes clock on input only.
// R2: wakeup select 0 uses slow internal osc; 1 uses divided fast external osc.
// R3: prescale field divides to 128 kHz: 0x=16 MHz, 10=8 MHz, 11=4 MHz.
// R4: settle code sets stabilisation count: 2048, 128, 8 or half a cycle.
// R5: a remap bit at 0 keeps default functions; only a 1 remaps pins.
// R6: option 7 puts timer1 complementary outputs 1 and 2 on C3 and C4.
// R7: option 6 puts timer1 channel 4 on D7.
// R8: option 5 puts the clock output on D0.
// R9: option 4 takes converter trigger from B4 and timer1 break from B5.
// R10: option 3 takes the top level interrupt from C3.
// R11: option 2 puts analog 2 on C4, analog 3 on D2, serial clock on D4.
// R12: programmer enables at most one remap option per port.
// R13: converter end or watchdog events raise priority 22, vector 0x008060.
// R14: option bytes captured at reset; decoded outputs held until next reset. Here a reload write at the status offset also recaptures them.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ocrd_defs.svh"
module ocrd_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic OSC_IN,
  input wire logic CONV_EOC_EVT,
  input wire logic CONV_AWD_EVT,
  output logic EXT_SOURCE_IS_CLOCK,
  output logic OSC_OUT_DRIVE_EN,
  output logic FAST_OSC_STABLE,
  output logic WAKEUP_CLOCK_SELECT,
  output logic [1:0] WAKEUP_PRESCALE_SEL,
  output logic [8:0] WAKEUP_DIV_QUARTERS,
  output logic [5:0] REMAP_ACTIVE,
  output logic [3:0] PC3_FN,
  output logic [3:0] PC4_FN,
  output logic [3:0] PD7_FN,
  output logic [3:0] PD0_FN,
  output logic [3:0] PB4_FN,
  output logic [3:0] PB5_FN,
  output logic [3:0] PD2_FN,
  output logic [3:0] PD4_FN,
  output logic REMAP_CONFLICT,
  output logic CONV_IRQ_REQ,
  output logic [4:0] CONV_IRQ_PRIO,
  output logic [23:0] CONV_IRQ_VECTOR
);
  ocrd_pkg::ocrd_state_e state;
  ocrd_pkg::ocrd_state_e next_state;
  logic [7:0] pin_remap_options;
  logic [7:0] clock_source_options;
  logic [7:0] oscillator_settle_count;
  logic [7:0] act_remap;
  logic [7:0] act_clk;
  logic [7:0] act_settle;
  logic reload_req;
  logic loaded;
  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic conflict_now;
  logic [31:0] next_readdata;

  ocrd_settle_if sif ();

  // settle count in oscillator half cycles
  function automatic logic [12:0] settle_half(input logic [7:0] code);
    case (code)
      `OCRD_SETTLE_CODE_2048: settle_half = `OCRD_SETTLE_HALF_2048;
      `OCRD_SETTLE_CODE_128: settle_half = `OCRD_SETTLE_HALF_128;
      `OCRD_SETTLE_CODE_8: settle_half = `OCRD_SETTLE_HALF_8;
      `OCRD_SETTLE_CODE_HALF: settle_half = `OCRD_SETTLE_HALF_HALF;
      // undefined codes fall back to the longest wait, the safe side
      default: settle_half = `OCRD_SETTLE_HALF_2048;
    endcase
  endfunction

  // wakeup divide ratio to 128 kHz, quarter steps
  function automatic logic [8:0] wake_div(input logic [1:0] sel);
    case (sel)
      2'h2: wake_div = `OCRD_WAKE_DIV_8M;
      2'h3: wake_div = `OCRD_WAKE_DIV_4M;
      default: wake_div = `OCRD_WAKE_DIV_16M;
    endcase
  endfunction

  // byte lane merge for an eight bit register in lane 0
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd,
                                       input logic [3:0] be);
    lane0 = be[0] ? wd[7:0] : old;
  endfunction

  // register bus: one wait cycle, then the request completes
  assign bus_req = AVS_READ | AVS_WRITE;
  assign bus_take = bus_req & !AVS_WAITREQUEST;
  assign wr_take = AVS_WRITE & !AVS_WAITREQUEST;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (bus_take) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (bus_req) begin
      AVS_WAITREQUEST <= 1'b0;
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    case (AVS_ADDRESS)
      `OCRD_OFS_REMAP: next_readdata[7:0] = pin_remap_options;
      `OCRD_OFS_CLKSRC: next_readdata[7:0] = clock_source_options;
      `OCRD_OFS_SETTLE: next_readdata[7:0] = oscillator_settle_count;
      `OCRD_OFS_STATUS: begin
        next_readdata[`OCRD_BIT_STABLE] = FAST_OSC_STABLE;
        next_readdata[`OCRD_BIT_CONFLICT] = REMAP_CONFLICT;
        next_readdata[`OCRD_BIT_LOADED] = loaded;
      end
      default: next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ && AVS_WAITREQUEST) begin
      AVS_READDATA <= next_readdata;
    end
  end

  // stored option bytes; they steer logic only through a capture
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_remap_options <= `OCRD_RST_REMAP;
      clock_source_options <= `OCRD_RST_CLKSRC;
      oscillator_settle_count <= `OCRD_RST_SETTLE;
    end else if (wr_take) begin
      if (AVS_ADDRESS == `OCRD_OFS_REMAP) begin
        pin_remap_options <= lane0(pin_remap_options, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (AVS_ADDRESS == `OCRD_OFS_CLKSRC) begin
        clock_source_options <= lane0(clock_source_options, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (AVS_ADDRESS == `OCRD_OFS_SETTLE) begin
        oscillator_settle_count <= lane0(oscillator_settle_count, AVS_WRITEDATA,
                                         AVS_BYTEENABLE);
      end
    end
  end

  // reload bit acts as an internal option reset
  assign reload_req = wr_take && (AVS_ADDRESS == `OCRD_OFS_STATUS) &&
                      AVS_BYTEENABLE[0] && AVS_WRITEDATA[`OCRD_BIT_RELOAD];

  // capture sequencer
  always_comb begin
    next_state = state;
    case (state)
      ocrd_pkg::ST_LOAD: next_state = ocrd_pkg::ST_SETTLE;
      ocrd_pkg::ST_SETTLE: if (sif.stable) next_state = ocrd_pkg::ST_RUN;
      ocrd_pkg::ST_RUN: next_state = ocrd_pkg::ST_RUN;
      default: next_state = ocrd_pkg::ST_LOAD;
    endcase
    if (reload_req) begin
      next_state = ocrd_pkg::ST_LOAD;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ocrd_pkg::ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // active copy is sampled only in the load state, never while running
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      act_remap <= `OCRD_RST_REMAP;
      act_clk <= `OCRD_RST_CLKSRC;
      act_settle <= `OCRD_RST_SETTLE;
      loaded <= 1'b0;
    end else if (state == ocrd_pkg::ST_LOAD) begin
      act_remap <= pin_remap_options; // [R14]
      act_clk <= clock_source_options; // [R14]
      act_settle <= oscillator_settle_count; // [R14]
      loaded <= 1'b1;
    end
  end

  // settle counter restarts with every capture
  assign sif.start = (state == ocrd_pkg::ST_LOAD);
  assign sif.target = settle_half(act_settle); // [R4]

  ocrd_settle u_settle (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .osc_in(OSC_IN),
    .sif(sif)
  );

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAST_OSC_STABLE <= 1'b0;
    end else begin
      FAST_OSC_STABLE <= (state == ocrd_pkg::ST_RUN); // [R4]
    end
  end

  // clock source outputs, refreshed from the held copy
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      EXT_SOURCE_IS_CLOCK <= 1'b0;
      OSC_OUT_DRIVE_EN <= 1'b0;
      WAKEUP_CLOCK_SELECT <= 1'b0;
      WAKEUP_PRESCALE_SEL <= 2'h0;
      WAKEUP_DIV_QUARTERS <= `OCRD_WAKE_DIV_16M;
    end else if (loaded) begin
      EXT_SOURCE_IS_CLOCK <= act_clk[`OCRD_BIT_EXT_IS_CLK]; // [R1]
      // crystal needs the output pin driven; an external clock does not
      OSC_OUT_DRIVE_EN <= !act_clk[`OCRD_BIT_EXT_IS_CLK]; // [R1]
      WAKEUP_CLOCK_SELECT <= act_clk[`OCRD_BIT_WAKESEL]; // [R2]
      WAKEUP_PRESCALE_SEL <= act_clk[`OCRD_BIT_DIV_HI:`OCRD_BIT_DIV_LO]; // [R3]
      WAKEUP_DIV_QUARTERS <= wake_div(act_clk[`OCRD_BIT_DIV_HI:`OCRD_BIT_DIV_LO]); // [R3]
    end
  end

  // same-port clash: C holds 7,3,2; D holds 6,5,2
  assign conflict_now =
    (act_remap[`OCRD_BIT_ALT7] & act_remap[`OCRD_BIT_ALT3]) |
    (act_remap[`OCRD_BIT_ALT7] & act_remap[`OCRD_BIT_ALT2]) |
    (act_remap[`OCRD_BIT_ALT3] & act_remap[`OCRD_BIT_ALT2]) |
    (act_remap[`OCRD_BIT_ALT6] & act_remap[`OCRD_BIT_ALT5]) |
    (act_remap[`OCRD_BIT_ALT6] & act_remap[`OCRD_BIT_ALT2]) |
    (act_remap[`OCRD_BIT_ALT5] & act_remap[`OCRD_BIT_ALT2]); // [R12]

  // pin mux selects; on a clash the higher option number wins the pin
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REMAP_ACTIVE <= 6'h00;
      REMAP_CONFLICT <= 1'b0;
    end else if (loaded) begin
      REMAP_ACTIVE <= act_remap[`OCRD_BIT_ALT7:`OCRD_BIT_ALT2]; // [R5]
      REMAP_CONFLICT <= conflict_now; // [R12]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PC3_FN <= ocrd_pkg::FN_DEFAULT;
    end else if (loaded) begin
      if (act_remap[`OCRD_BIT_ALT7]) begin
        PC3_FN <= ocrd_pkg::FN_T1_COMP1; // [R6]
      end else if (act_remap[`OCRD_BIT_ALT3]) begin
        PC3_FN <= ocrd_pkg::FN_TOP_IRQ; // [R10]
      end else begin
        PC3_FN <= ocrd_pkg::FN_DEFAULT; // [R5]
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PC4_FN <= ocrd_pkg::FN_DEFAULT;
    end else if (loaded) begin
      if (act_remap[`OCRD_BIT_ALT7]) begin
        PC4_FN <= ocrd_pkg::FN_T1_COMP2; // [R6]
      end else if (act_remap[`OCRD_BIT_ALT2]) begin
        PC4_FN <= ocrd_pkg::FN_ANALOG2; // [R11]
      end else begin
        PC4_FN <= ocrd_pkg::FN_DEFAULT; // [R5]
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PD7_FN <= ocrd_pkg::FN_DEFAULT;
    end else if (loaded) begin
      PD7_FN <= act_remap[`OCRD_BIT_ALT6] ? ocrd_pkg::FN_T1_CH4
                                           : ocrd_pkg::FN_DEFAULT; // [R7]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PD0_FN <= ocrd_pkg::FN_DEFAULT;
    end else if (loaded) begin
      PD0_FN <= act_remap[`OCRD_BIT_ALT5] ? ocrd_pkg::FN_CLK_OUT
                                           : ocrd_pkg::FN_DEFAULT; // [R8]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PB4_FN <= ocrd_pkg::FN_DEFAULT;
    end else if (loaded) begin
      PB4_FN <= act_remap[`OCRD_BIT_ALT4] ? ocrd_pkg::FN_CONV_TRIG
                                           : ocrd_pkg::FN_DEFAULT; // [R9]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PB5_FN <= ocrd_pkg::FN_DEFAULT;
    end else if (loaded) begin
      PB5_FN <= act_remap[`OCRD_BIT_ALT4] ? ocrd_pkg::FN_T1_BREAK
                                           : ocrd_pkg::FN_DEFAULT; // [R9]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PD2_FN <= ocrd_pkg::FN_DEFAULT;
    end else if (loaded) begin
      PD2_FN <= act_remap[`OCRD_BIT_ALT2] ? ocrd_pkg::FN_ANALOG3
                                           : ocrd_pkg::FN_DEFAULT; // [R11]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PD4_FN <= ocrd_pkg::FN_DEFAULT;
    end else if (loaded) begin
      PD4_FN <= act_remap[`OCRD_BIT_ALT2] ? ocrd_pkg::FN_SER_CLK
                                           : ocrd_pkg::FN_DEFAULT; // [R11]
    end
  end

  // converter interrupt request, a level that follows either event one cycle later
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CONV_IRQ_REQ <= 1'b0;
      CONV_IRQ_PRIO <= `OCRD_CONV_IRQ_PRIO;
      CONV_IRQ_VECTOR <= `OCRD_CONV_IRQ_VECTOR;
    end else begin
      CONV_IRQ_REQ <= CONV_EOC_EVT | CONV_AWD_EVT; // [R13]
      CONV_IRQ_PRIO <= `OCRD_CONV_IRQ_PRIO; // [R13]
      CONV_IRQ_VECTOR <= `OCRD_CONV_IRQ_VECTOR; // [R13]
    end
  end
endmodule
`default_nettype wire

// ===== design/ocrd_defs.svh
// constants for the option byte clock and remap decoder
// assumes inclusion by bare name from the design top and the test bench
`ifndef OCRD_DEFS_SVH
`define OCRD_DEFS_SVH

// register byte offsets
`define OCRD_OFS_REMAP 4'h0
`define OCRD_OFS_CLKSRC 4'h4
`define OCRD_OFS_SETTLE 4'h8
`define OCRD_OFS_STATUS 4'hC

// option byte reset values
`define OCRD_RST_REMAP 8'h00
`define OCRD_RST_CLKSRC 8'h00
`define OCRD_RST_SETTLE 8'h00

// clock_source_options field positions
`define OCRD_BIT_EXT_IS_CLK 3
`define OCRD_BIT_WAKESEL 2
`define OCRD_BIT_DIV_HI 1
`define OCRD_BIT_DIV_LO 0

// pin_remap_options field positions
`define OCRD_BIT_ALT7 7
`define OCRD_BIT_ALT6 6
`define OCRD_BIT_ALT5 5
`define OCRD_BIT_ALT4 4
`define OCRD_BIT_ALT3 3
`define OCRD_BIT_ALT2 2

// status field positions
`define OCRD_BIT_STABLE 0
`define OCRD_BIT_CONFLICT 1
`define OCRD_BIT_LOADED 2
// control bit, written at the status offset
`define OCRD_BIT_RELOAD 0

// crystal settle codes and their counts in oscillator half cycles
`define OCRD_SETTLE_CODE_2048 8'h00
`define OCRD_SETTLE_CODE_128 8'hB4
`define OCRD_SETTLE_CODE_8 8'hD2
`define OCRD_SETTLE_CODE_HALF 8'hE1
`define OCRD_SETTLE_HALF_2048 13'h1000
`define OCRD_SETTLE_HALF_128 13'h0100
`define OCRD_SETTLE_HALF_8 13'h0010
`define OCRD_SETTLE_HALF_HALF 13'h0001

// wakeup divide ratio to 128 kHz, in quarter steps
`define OCRD_WAKE_DIV_16M 9'h1F4
`define OCRD_WAKE_DIV_8M 9'h0FA
`define OCRD_WAKE_DIV_4M 9'h07D

// converter interrupt
`define OCRD_CONV_IRQ_PRIO 5'h16
`define OCRD_CONV_IRQ_VECTOR 24'h008060

`endif

// ===== design/ocrd_pkg.sv
// types for the option byte clock and remap decoder
// assumes nothing beyond a SystemVerilog compiler
package ocrd_pkg;

  typedef enum logic [2:0] {
    ST_LOAD = 3'h1,
    ST_SETTLE = 3'h2,
    ST_RUN = 3'h4
  } ocrd_state_e;

  typedef enum logic [3:0] {
    FN_DEFAULT = 4'h0,
    FN_T1_COMP1 = 4'h1,
    FN_T1_COMP2 = 4'h2,
    FN_T1_CH4 = 4'h3,
    FN_CLK_OUT = 4'h4,
    FN_CONV_TRIG = 4'h5,
    FN_T1_BREAK = 4'h6,
    FN_TOP_IRQ = 4'h7,
    FN_ANALOG2 = 4'h8,
    FN_ANALOG3 = 4'h9,
    FN_SER_CLK = 4'hA
  } ocrd_fn_e;

endpackage

// ===== design/ocrd_settle_if.sv
// link between the decoder and its crystal settle counter
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ocrd_settle_if;
  logic start;
  logic [12:0] target;
  logic stable;
  modport ctrl (output start, output target, input stable);
  modport counter (input start, input target, output stable);
endinterface
`default_nettype wire

// ===== design/ocrd_settle.sv
// crystal settle counter: counts oscillator half cycles
// assumes osc_in is asynchronous to clk and far slower than it
`timescale 1ns/1ps
`default_nettype none
module ocrd_settle (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_in,
  ocrd_settle_if.counter sif
);
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic [12:0] cnt;
  logic stable;
  logic half_edge;

  // sync_a feeds sync_b only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= osc_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // each level change is one half cycle of the oscillator
  assign half_edge = sync_b ^ sync_c;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 13'h0000;
      stable <= 1'b0;
    end else if (sif.start) begin
      cnt <= 13'h0000;
      stable <= 1'b0;
    end else if (!stable && half_edge) begin
      cnt <= cnt + 13'h0001;
      if ((cnt + 13'h0001) >= sif.target) begin
        stable <= 1'b1; // [R4]
      end
    end
  end

  assign sif.stable = stable;
endmodule
`default_nettype wire

// ===== dv/ocrd_asserts.sv
// port checker for the option byte decoder top
// assumes REF_CLK only and RST_N async low, bound into ocrd_top
`timescale 1ns/1ps
`default_nettype none
module ocrd_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic CONV_EOC_EVT,
  input wire logic CONV_AWD_EVT,
  input wire logic EXT_SOURCE_IS_CLOCK,
  input wire logic OSC_OUT_DRIVE_EN,
  input wire logic FAST_OSC_STABLE,
  input wire logic [1:0] WAKEUP_PRESCALE_SEL,
  input wire logic [8:0] WAKEUP_DIV_QUARTERS,
  input wire logic [5:0] REMAP_ACTIVE,
  input wire logic [3:0] PC3_FN,
  input wire logic [3:0] PC4_FN,
  input wire logic [3:0] PD7_FN,
  input wire logic [3:0] PD0_FN,
  input wire logic [3:0] PB4_FN,
  input wire logic [3:0] PB5_FN,
  input wire logic [3:0] PD2_FN,
  input wire logic [3:0] PD4_FN,
  input wire logic CONV_IRQ_REQ,
  input wire logic [4:0] CONV_IRQ_PRIO,
  input wire logic [23:0] CONV_IRQ_VECTOR
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [1:0] up;
  logic req;
  logic reload;
  assign req = AVS_READ || AVS_WRITE;
  assign reload = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'hC && AVS_WRITEDATA[0];
  // decoded outputs are only trusted three edges after reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  a_wait_one: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  a_wait_short: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!req |=> AVS_WAITREQUEST)
    else $error("waitrequest low without request");
  a_osc_drive_inv: assert property (up == 2'h3 |->
    OSC_OUT_DRIVE_EN == !EXT_SOURCE_IS_CLOCK)
    else $error("crystal driver not inverse of clock select");
  a_irq_delay: assert property (up != 2'h0 |->
    CONV_IRQ_REQ == $past(CONV_EOC_EVT || CONV_AWD_EVT))
    else $error("converter request not one cycle after event");
  a_irq_consts: assert property (CONV_IRQ_PRIO == 5'h16 && CONV_IRQ_VECTOR == 24'h008060)
    else $error("converter priority or vector wrong");
  a_div_map: assert property (WAKEUP_DIV_QUARTERS == (WAKEUP_PRESCALE_SEL[1] ?
    (WAKEUP_PRESCALE_SEL[0] ? 9'h07D : 9'h0FA) : 9'h1F4))
    else $error("wakeup divide ratio wrong");
  a_c_port_map: assert property ($stable(REMAP_ACTIVE) |->
    PC3_FN == (REMAP_ACTIVE[5] ? ocrd_pkg::FN_T1_COMP1 :
    (REMAP_ACTIVE[1] ? ocrd_pkg::FN_TOP_IRQ : ocrd_pkg::FN_DEFAULT)) &&
    PC4_FN == (REMAP_ACTIVE[5] ? ocrd_pkg::FN_T1_COMP2 :
    (REMAP_ACTIVE[0] ? ocrd_pkg::FN_ANALOG2 : ocrd_pkg::FN_DEFAULT)))
    else $error("port C function wrong");
  a_d_port_map: assert property ($stable(REMAP_ACTIVE) |->
    PD7_FN == (REMAP_ACTIVE[4] ? ocrd_pkg::FN_T1_CH4 : ocrd_pkg::FN_DEFAULT) &&
    PD0_FN == (REMAP_ACTIVE[3] ? ocrd_pkg::FN_CLK_OUT : ocrd_pkg::FN_DEFAULT) &&
    PD2_FN == (REMAP_ACTIVE[0] ? ocrd_pkg::FN_ANALOG3 : ocrd_pkg::FN_DEFAULT) &&
    PD4_FN == (REMAP_ACTIVE[0] ? ocrd_pkg::FN_SER_CLK : ocrd_pkg::FN_DEFAULT))
    else $error("port D function wrong");
  a_b_port_map: assert property ($stable(REMAP_ACTIVE) |->
    PB4_FN == (REMAP_ACTIVE[2] ? ocrd_pkg::FN_CONV_TRIG : ocrd_pkg::FN_DEFAULT) &&
    PB5_FN == (REMAP_ACTIVE[2] ? ocrd_pkg::FN_T1_BREAK : ocrd_pkg::FN_DEFAULT))
    else $error("port B function wrong");
  a_remap_held: assert property ($changed(REMAP_ACTIVE) ||
    $changed(EXT_SOURCE_IS_CLOCK) |-> $past(reload, 2) || $past(reload, 3))
    else $error("decoded options changed without reload");
  cover property (CONV_IRQ_REQ);
  cover property ($rose(FAST_OSC_STABLE));
  cover property (REMAP_ACTIVE[5] && PC3_FN == ocrd_pkg::FN_T1_COMP1);
endmodule

bind ocrd_top ocrd_chk u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONV_EOC_EVT(CONV_EOC_EVT), .CONV_AWD_EVT(CONV_AWD_EVT),
  .EXT_SOURCE_IS_CLOCK(EXT_SOURCE_IS_CLOCK), .OSC_OUT_DRIVE_EN(OSC_OUT_DRIVE_EN),
  .FAST_OSC_STABLE(FAST_OSC_STABLE), .WAKEUP_PRESCALE_SEL(WAKEUP_PRESCALE_SEL),
  .WAKEUP_DIV_QUARTERS(WAKEUP_DIV_QUARTERS), .REMAP_ACTIVE(REMAP_ACTIVE), .PC3_FN(PC3_FN),
  .PC4_FN(PC4_FN), .PD7_FN(PD7_FN), .PD0_FN(PD0_FN), .PB4_FN(PB4_FN), .PB5_FN(PB5_FN),
  .PD2_FN(PD2_FN), .PD4_FN(PD4_FN), .CONV_IRQ_REQ(CONV_IRQ_REQ),
  .CONV_IRQ_PRIO(CONV_IRQ_PRIO), .CONV_IRQ_VECTOR(CONV_IRQ_VECTOR));
`default_nettype wire

// ===== dv/option_byte_clock_and_remap_decode_test.sv
// self-checking bench for the option byte decoder
// assumes ocrd_top with its checker bound, REF_CLK at 20 MHz
`timescale 1ns/1ps
`default_nettype none
`include "ocrd_defs.svh"
module option_byte_clock_and_remap_decode_test;
  logic clk, rst_n, rd, wr, osc, eoc, awd, waitreq, ext, oen, stable, wsel, conflict, irq;
  logic [3:0] addr, be, pc3, pc4, pd7, pd0, pb4, pb5, pd2, pd4;
  logic [31:0] wdata, rdata, q;
  logic [1:0] psel, ocnt;
  logic [8:0] divq;
  logic [5:0] act;
  logic [4:0] prio;
  logic [23:0] vec;
  logic [7:0] o;
  logic [7:0] tbl [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'hD0, 8'h28};
  int errors, n_checks, toggles;
  ocrd_top dut (.REF_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .OSC_IN(osc), .CONV_EOC_EVT(eoc), .CONV_AWD_EVT(awd),
    .EXT_SOURCE_IS_CLOCK(ext), .OSC_OUT_DRIVE_EN(oen), .FAST_OSC_STABLE(stable),
    .WAKEUP_CLOCK_SELECT(wsel), .WAKEUP_PRESCALE_SEL(psel), .WAKEUP_DIV_QUARTERS(divq),
    .REMAP_ACTIVE(act), .PC3_FN(pc3), .PC4_FN(pc4), .PD7_FN(pd7), .PD0_FN(pd0),
    .PB4_FN(pb4), .PB5_FN(pb5), .PD2_FN(pd2), .PD4_FN(pd4), .REMAP_CONFLICT(conflict),
    .CONV_IRQ_REQ(irq), .CONV_IRQ_PRIO(prio), .CONV_IRQ_VECTOR(vec));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // crystal stand-in, kept slow so the two-flop sync sees every change
  always @(posedge clk) begin
    ocnt <= ocnt + 2'h1;
    if (ocnt == 2'h3) begin
      osc <= ~osc;
      toggles <= toggles + 1;
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b);
    int i;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (waitreq !== 1'b0 && i < 40);
    if (i >= 40) begin
      errors++;
      stop_test();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // counts crystal changes between reload and stable; sync lag gives slack
  task automatic settle(input logic [7:0] code, input int tgt);
    int i, t0;
    bus(1'b1, `OCRD_OFS_SETTLE, code, 4'h1);
    bus(1'b1, `OCRD_OFS_STATUS, 8'h01, 4'h1);
    t0 = toggles;
    repeat (3) @(posedge clk);
    chk("stable after reload", 32'h0, {31'h0, stable});
    i = 0;
    while (stable !== 1'b1 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 20000) begin
      errors++;
      stop_test();
    end
    i = toggles - t0;
    chk("settle span", 32'h1, {31'h0, (i >= tgt - 1) && (i <= tgt + 3)});
    bus(1'b0, `OCRD_OFS_STATUS, 8'h00, 4'h1);
    chk("status", 32'h5, q);
  endtask
  task automatic check_outputs(input logic [7:0] r, input logic [3:0] c);
    logic [31:0] e;
    e[31:28] = r[7] ? ocrd_pkg::FN_T1_COMP1 : (r[3] ? ocrd_pkg::FN_TOP_IRQ : ocrd_pkg::FN_DEFAULT);
    e[27:24] = r[7] ? ocrd_pkg::FN_T1_COMP2 : (r[2] ? ocrd_pkg::FN_ANALOG2 : ocrd_pkg::FN_DEFAULT);
    e[23:20] = r[6] ? ocrd_pkg::FN_T1_CH4 : ocrd_pkg::FN_DEFAULT;
    e[19:16] = r[5] ? ocrd_pkg::FN_CLK_OUT : ocrd_pkg::FN_DEFAULT;
    e[15:12] = r[4] ? ocrd_pkg::FN_CONV_TRIG : ocrd_pkg::FN_DEFAULT;
    e[11:8] = r[4] ? ocrd_pkg::FN_T1_BREAK : ocrd_pkg::FN_DEFAULT;
    e[7:4] = r[2] ? ocrd_pkg::FN_ANALOG3 : ocrd_pkg::FN_DEFAULT;
    e[3:0] = r[2] ? ocrd_pkg::FN_SER_CLK : ocrd_pkg::FN_DEFAULT;
    chk("pins", e, {pc3, pc4, pd7, pd0, pb4, pb5, pd2, pd4});
    chk("active", {26'h0, r[7:2]}, {26'h0, act});
    chk("conflict", 32'h0, {31'h0, conflict});
    chk("ext source", {31'h0, c[3]}, {31'h0, ext});
    chk("osc drive", {31'h0, ~c[3]}, {31'h0, oen});
    chk("wakeup sel", {31'h0, c[2]}, {31'h0, wsel});
    chk("prescale", {30'h0, c[1:0]}, {30'h0, psel});
    chk("divide", {23'h0, c[1] ? (c[0] ? 9'h07D : 9'h0FA) : 9'h1F4}, {23'h0, divq});
  endtask
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    be = 4'h0;
    osc = 1'b0;
    ocnt = 2'h0;
    eoc = 1'b0;
    awd = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, (k == 3) ? 4'h2 : 4'(k * 4), 8'h00, 4'h1);
      chk("reset value", 32'h0, q);
    end
    bus(1'b1, `OCRD_OFS_REMAP, 8'hFF, 4'h0);
    bus(1'b0, `OCRD_OFS_REMAP, 8'h00, 4'h1);
    chk("lane off", 32'h0, q);
    settle(8'h00, 4096);
    settle(8'hB4, 256);
    settle(8'hD2, 16);
    settle(8'hE1, 1);
    for (int i = 0; i < 16; i++) begin
      o = tbl[i % 8];
      bus(1'b1, `OCRD_OFS_REMAP, o, 4'h1);
      bus(1'b1, `OCRD_OFS_CLKSRC, 8'(i), 4'h1);
      bus(1'b0, `OCRD_OFS_CLKSRC, 8'h00, 4'h1);
      chk("clock reg", 32'(i), q);
      bus(1'b1, `OCRD_OFS_STATUS, 8'h01, 4'h1);
      repeat (3) @(posedge clk);
      check_outputs(o, 4'(i));
    end
    bus(1'b1, `OCRD_OFS_REMAP, 8'h80, 4'h1);
    bus(1'b1, `OCRD_OFS_CLKSRC, 8'h00, 4'h1);
    repeat (4) @(posedge clk);
    check_outputs(8'h28, 4'hF);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      eoc <= (j == 0);
      awd <= (j == 1);
      @(posedge clk);
      eoc <= 1'b0;
      awd <= 1'b0;
      @(posedge clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      @(posedge clk);
      chk("irq dropped", 32'h0, {31'h0, irq});
    end
    chk("irq prio", 32'h16, {27'h0, prio});
    chk("irq vector", 32'h00008060, {8'h0, vec});
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    chk("reset active", 32'h0, {26'h0, act});
    rst_n <= 1'b1;
    bus(1'b0, `OCRD_OFS_REMAP, 8'h00, 4'h1);
    chk("remap after reset", 32'h0, q);
    check_outputs(8'h00, 4'h0);
    stop_test();
  end
endmodule
`default_nettype wire
